// ==== tmtc_pkg.sv ====
// shared constants and types for the trigger and multi-drop transmit control
package tmtc_pkg;
  // clock and internal sample rate
  localparam int CLK_HZ          = 25000000;
  localparam int SAMPLE_HZ       = 2000;
  localparam int SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
  // character framing
  localparam int START_BITS      = 1;
  localparam int DATA_BITS       = 8;
  // default preparation delay and minimum gap, in us
  localparam int PREP_US         = 20;
  localparam int GAP_MIN_US      = 10;
  localparam int PREP_CYC        = (PREP_US * (CLK_HZ / 1000000));
  localparam int GAP_MIN_CYC     = (GAP_MIN_US * (CLK_HZ / 1000000));
  // number of start-up special datagrams
  localparam int STARTUP_CNT     = 4;
  // axi register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BAUD   = 8'h04;
  localparam logic [7:0] REG_FRAME  = 8'h08;
  localparam logic [7:0] REG_GAP    = 8'h0C;
  localparam logic [7:0] REG_START  = 8'h10;
  localparam logic [7:0] REG_SPEC   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_CNTMAX = 8'h1C;
  // control register fields
  localparam int CTL_TRIG    = 0;
  localparam int CTL_MDROP   = 1;
  localparam int CTL_TRIS    = 2;
  localparam int CTL_NOSTART = 3;
  localparam int CTL_STOPB   = 4;
  localparam int CTL_PARITY  = 5;
  localparam int CTL_SVCON   = 6;
  localparam int CTL_SVCOWN  = 7;
  localparam int CTL_CFGMODE = 8;
  localparam int ID_LSB      = 16;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] BAUD_RST   = 16'h00D9;
  localparam logic [15:0] FRAME_RST  = 16'h0010;
  localparam logic [15:0] CNTMAX_RST = 16'hFFFF;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // transmit sequencer states, gray along init-idle-wait-send
  typedef enum logic [2:0] {
    TMTC_INIT = 3'b000,
    TMTC_IDLE = 3'b001,
    TMTC_WAIT = 3'b011,
    TMTC_SEND = 3'b010,
    TMTC_HOLD = 3'b110
  } tmtc_state_t;
endpackage

// ==== tmtc_top.sv ====
// transmit control: trigger, multi-drop scheduling and axi4-lite registers
`timescale 1ns/1ps
module tmtc_top
  import tmtc_pkg::*;
#(
  parameter int ID_W = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        remote_fire_input,
  input  wire logic        frameDone,
  output logic             frameStart,
  output logic             frameSpecial,
  output logic [2:0]       frameKind,
  output logic             lineDriveOe_n,
  output logic             validity_strobe,
  output logic             count_restart_pulse,
  output logic [15:0]      sampleCount,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // byte-lane merge used by every register write except the special request
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // reset synchroniser: async assert, two-flop release
  logic rstMeta_ff;                 // first stage, read only by second
  logic rstSync_ff;                 // released reset for the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire logic srst_n = rstSync_ff;

  // registers
  logic [31:0]   ctrl_ff;           // mode bits and unit position id
  logic [15:0]   baudDiv_ff;        // clock cycles per bit
  logic [15:0]   frameLen_ff;       // datagram length in characters
  logic [31:0]   gapCyc_ff;         // requested datagram gap, cycles
  logic [31:0]   startCyc_ff;       // requested start-to-start, cycles
  logic [15:0]   cntMax_ff;         // sample counter restart value
  logic [2:0]    specKind_ff;       // latest special request kind
  logic          specPend_ff;       // special request waiting
  logic [ID_W-1:0] unit_position_id;
  tmtc_state_t   state_ff;          // transmit sequencer state, read back in status

  assign unit_position_id = ctrl_ff[ID_LSB +: ID_W];

  // axi write path
  logic        awHave_ff;
  logic        wHave_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        wrFire;
  logic        specWrite;
  assign s_axi_awready = !awHave_ff && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_ff && !s_axi_bvalid;
  assign wrFire = awHave_ff && wHave_ff && !s_axi_bvalid;
  assign specWrite = wrFire && (awAddr_ff == REG_SPEC) && wStrb_ff[0];
  wire logic [31:0] ctrlMerged = laneMerge(ctrl_ff, wData_ff, wStrb_ff); // control word after lane merge

  // capture address and data in either order
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      awHave_ff <= 1'b0;
      wHave_ff  <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (wrFire) begin
        awHave_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (wrFire) begin
        wHave_ff <= 1'b0;
      end
    end
  end

  // write response, okay at offsets up to REG_SPEC and at REG_CNTMAX, slverr elsewhere
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_ff <= REG_SPEC || awAddr_ff == REG_CNTMAX) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_ff     <= CTRL_RST;
      baudDiv_ff  <= BAUD_RST;
      frameLen_ff <= FRAME_RST;
      gapCyc_ff   <= 32'h0000_0000;
      startCyc_ff <= 32'h0000_0000;
      cntMax_ff   <= CNTMAX_RST;
    end else if (wrFire) begin
      case (awAddr_ff)
        REG_CTRL: begin
          ctrl_ff <= ctrlMerged;
          if (!ctrlMerged[CTL_TRIG]) begin
            ctrl_ff[CTL_MDROP] <= 1'b0;
          end
          if (!ctrl_ff[CTL_CFGMODE]) begin
            // a refused multi-drop request must not latch the disable
            ctrl_ff[CTL_TRIS] <= ctrl_ff[CTL_TRIS] | (ctrlMerged[CTL_MDROP] & ctrlMerged[CTL_TRIG]);
          end
        end
        REG_BAUD:   baudDiv_ff  <= 16'(laneMerge({16'h0000, baudDiv_ff}, wData_ff, wStrb_ff));
        REG_FRAME:  frameLen_ff <= 16'(laneMerge({16'h0000, frameLen_ff}, wData_ff, wStrb_ff));
        REG_GAP:    gapCyc_ff   <= laneMerge(gapCyc_ff, wData_ff, wStrb_ff);
        REG_START:  startCyc_ff <= laneMerge(startCyc_ff, wData_ff, wStrb_ff);
        REG_CNTMAX: cntMax_ff   <= 16'(laneMerge({16'h0000, cntMax_ff}, wData_ff, wStrb_ff));
        default: ;
      endcase
    end
  end

  // axi read path
  logic [31:0] rdMux;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (s_axi_araddr)
      REG_CTRL:   rdMux = ctrl_ff;
      REG_BAUD:   rdMux = {16'h0000, baudDiv_ff};
      REG_FRAME:  rdMux = {16'h0000, frameLen_ff};
      REG_GAP:    rdMux = gapCyc_ff;
      REG_START:  rdMux = startCyc_ff;
      REG_SPEC:   rdMux = {28'h0000000, specPend_ff, specKind_ff};
      REG_STATUS: rdMux = {13'h0000, state_ff, sampleCount};
      REG_CNTMAX: rdMux = {16'h0000, cntMax_ff};
      default:    rdMux = 32'h0000_0000;
    endcase
  end

  // read data register, one cycle after address
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= (s_axi_araddr <= REG_CNTMAX && s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sample-rate divider and sample counter
  logic [15:0] divCnt_ff;
  logic        sampleTick;
  assign sampleTick = (divCnt_ff == 16'(SAMPLE_CYC - 1));
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      divCnt_ff   <= 16'h0000;
      sampleCount <= 16'h0000;
      count_restart_pulse <= 1'b0;
    end else begin
      divCnt_ff <= sampleTick ? 16'h0000 : divCnt_ff + 16'h0001;
      count_restart_pulse <= 1'b0;
      if (sampleTick) begin
        if (sampleCount >= cntMax_ff) begin
          sampleCount <= 16'h0000;
          count_restart_pulse <= 1'b1;
        end else begin
          sampleCount <= sampleCount + 16'h0001;
        end
      end
    end
  end

  // trigger edge detect; pin treated as synchronous
  logic fireLast_ff;
  logic fireFall;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      fireLast_ff <= 1'b1;
    end else begin
      fireLast_ff <= remote_fire_input;
    end
  end
  assign fireFall = fireLast_ff && !remote_fire_input;

  // mode decode
  logic trigMode;
  logic mdrop;
  logic muted;
  assign trigMode = ctrl_ff[CTL_TRIG];
  assign mdrop    = ctrl_ff[CTL_MDROP];
  assign muted    = ctrl_ff[CTL_SVCON] && !ctrl_ff[CTL_SVCOWN];

  // scheduling arithmetic, slot length in cycles
  logic [3:0]  charBits;
  logic [31:0] frameCyc;
  logic [31:0] gapUse;
  logic [31:0] minDelay;
  logic [31:0] delayUse;
  assign charBits = 4'(START_BITS + DATA_BITS) + (ctrl_ff[CTL_STOPB] ? 4'd2 : 4'd1) + {3'b000, ctrl_ff[CTL_PARITY]};
  assign frameCyc = 32'(baudDiv_ff) * 32'(charBits) * 32'(frameLen_ff);
  assign gapUse   = (gapCyc_ff < 32'(GAP_MIN_CYC)) ? 32'(GAP_MIN_CYC) : gapCyc_ff;
  assign minDelay = 32'(PREP_CYC) + 32'(unit_position_id) * (frameCyc + gapUse);
  assign delayUse = (startCyc_ff * 32'(unit_position_id) > minDelay) ?
                    startCyc_ff * 32'(unit_position_id) : minDelay;

  // special request holding, newest wins, set beats clear
  logic takeSpec;
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      specPend_ff <= 1'b0;
      specKind_ff <= 3'h0;
    end else if (specWrite) begin
      specPend_ff <= 1'b1;
      specKind_ff <= wData_ff[2:0];
    end else if (takeSpec) begin
      specPend_ff <= 1'b0;
    end
  end

  // transmit sequencer
  logic [31:0] waitCnt_ff;
  logic [2:0]  initLeft_ff;
  logic        sending;
  assign sending = (state_ff == TMTC_SEND);
  assign takeSpec = (state_ff == TMTC_WAIT) && (waitCnt_ff == 32'h0) && specPend_ff && !specWrite;

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff     <= TMTC_INIT;
      waitCnt_ff   <= 32'h0000_0000;
      initLeft_ff  <= 3'(STARTUP_CNT);
      frameStart   <= 1'b0;
      frameSpecial <= 1'b0;
      frameKind    <= 3'h0;
    end else begin
      frameStart <= 1'b0;
      case (state_ff)
        TMTC_INIT: begin
          if (initLeft_ff == 3'h0 || (mdrop && ctrl_ff[CTL_NOSTART])) begin
            state_ff <= TMTC_IDLE;
          end else begin
            waitCnt_ff <= mdrop ? delayUse * 32'(STARTUP_CNT) : 32'h0;
            state_ff   <= TMTC_HOLD;
          end
        end
        TMTC_HOLD: begin
          if (waitCnt_ff != 32'h0) begin
            waitCnt_ff <= waitCnt_ff - 32'h1;
          end else begin
            frameStart   <= 1'b1;
            frameSpecial <= 1'b1;
            frameKind    <= 3'(STARTUP_CNT) - initLeft_ff;
            initLeft_ff  <= initLeft_ff - 3'h1;
            state_ff     <= TMTC_SEND;
          end
        end
        TMTC_IDLE: begin
          if (muted) begin
            state_ff <= TMTC_IDLE;
          end else if (!trigMode && sampleTick) begin
            waitCnt_ff <= 32'h0;
            state_ff   <= TMTC_WAIT;
          end else if (trigMode && fireFall) begin
            waitCnt_ff <= mdrop ? delayUse : 32'h0;
            state_ff   <= TMTC_WAIT;
          end
        end
        TMTC_WAIT: begin
          if (waitCnt_ff != 32'h0) begin
            waitCnt_ff <= waitCnt_ff - 32'h1;
          end else begin
            frameStart <= 1'b1;
            frameSpecial <= takeSpec;
            frameKind    <= takeSpec ? specKind_ff : 3'h0;
            state_ff     <= TMTC_SEND;
          end
        end
        TMTC_SEND: begin
          if (frameDone) begin
            state_ff <= (initLeft_ff != 3'h0) ? TMTC_HOLD : TMTC_IDLE;
            waitCnt_ff <= 32'h0;
          end
        end
        default: state_ff <= TMTC_INIT;
      endcase
    end
  end

  // line driver enable, low means driving
  // driver off between frames once tristate is latched, else on unless muted
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      lineDriveOe_n <= 1'b1;
    end else begin
      lineDriveOe_n <= ctrl_ff[CTL_TRIS] ? !(sending || frameStart) : muted;
    end
  end

  // validity strobe: falls on sample (free-run) or frame start (trigger), rises at frame end
  // stays active in multi-drop
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      validity_strobe <= 1'b1;
    end else if (sampleTick && !trigMode) begin
      validity_strobe <= 1'b0;
    end else if (frameStart && trigMode) begin
      validity_strobe <= 1'b0;
    end else if (sending && frameDone) begin
      validity_strobe <= 1'b1;
    end
  end
endmodule

// ==== tmtc_top_assertions.sv ====
// port checker for the transmit control block
`timescale 1ns/1ps
module tmtc_top_assertions
  import tmtc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        frameStart,
  input wire logic        frameDone,
  input wire logic        validity_strobe,
  input wire logic        count_restart_pulse,
  input wire logic [15:0] sampleCount,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic inFlight_ff; // a frame is with the serialiser
  // track frames between start and done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inFlight_ff <= 1'b0;
    end else if (frameStart) begin
      inFlight_ff <= 1'b1;
    end else if (frameDone) begin
      inFlight_ff <= 1'b0;
    end
  end
  default clocking cbk @(posedge clk); endclocking
  default disable iff (!rst_n);
  start_pulse_a: assert property (frameStart |=> !frameStart)
    else $error("frame start longer than one cycle");
  one_frame_a: assert property (frameStart |-> !inFlight_ff)
    else $error("frame started while one in flight");
  wrap_pulse_a: assert property ($rose(count_restart_pulse) |-> sampleCount == 16'h0000 || $past(sampleCount) == 16'h0000)
    else $error("restart pulse away from zero");
  count_step_a: assert property (sampleCount != $past(sampleCount) |-> sampleCount == $past(sampleCount) + 16'h0001 || sampleCount == 16'h0000)
    else $error("sample counter jumped");
  valid_rise_a: assert property ($rose(validity_strobe) |-> $past(frameDone))
    else $error("validity rose without frame done");
  // response held until taken
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule

bind tmtc_top tmtc_top_assertions u_chk (.clk(clk), .rst_n(rst_n), .frameStart(frameStart), .frameDone(frameDone),
  .validity_strobe(validity_strobe), .count_restart_pulse(count_restart_pulse), .sampleCount(sampleCount),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tmtc_link_model.sv ====
// serialiser stand-in: ends each frame after a set latency
`timescale 1ns/1ps
module tmtc_link_model
  import tmtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       frameStart,
  input  wire logic [7:0] latency,
  output logic            frameDone,
  output logic            busy
);
  logic [7:0] left_ff; // cycles left in frame
  logic       busy_ff; // frame being shifted
  logic       done_ff; // last bit out
  assign busy      = busy_ff;
  assign frameDone = done_ff;
  // latency taken at start, so quick and slow frames both occur
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      left_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (frameStart) begin
        busy_ff <= 1'b1;
        left_ff <= latency;
      end else if (busy_ff && left_ff == 8'h00) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (busy_ff) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule

// ==== trigger_multidrop_tx_control_tb.sv ====
// self-checking bench for the transmit control block
`timescale 1ns/1ps
module trigger_multidrop_tx_control_tb
  import tmtc_pkg::*;
();
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} tmtc_rexp_t;
  typedef struct {logic sp; logic [2:0] k; int lo; int hi;} tmtc_fexp_t;
  logic clk = 1'b0, rst_n = 1'b0, remote_fire_input = 1'b1, frameDone, busy;
  logic frameStart, frameSpecial, lineDriveOe_n, validity_strobe, count_restart_pulse;
  logic [2:0] frameKind;
  logic [15:0] sampleCount;
  logic [7:0] lat = 8'h14, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hD576E947;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic strict = 1'b0, prevFire = 1'b1, kindDue = 1'b0;
  logic [3:0] strb = 4'hF;
  int n_fail = 0, samples_checked = 0, cyc = 0, fallCyc = 0, frames = 0, wraps = 0;
  int gap, st, cl, slot, d;
  tmtc_rexp_t rq[$];
  tmtc_rexp_t rx;
  logic [1:0] bq[$];
  tmtc_fexp_t fq[$];
  tmtc_fexp_t cur;
  always #20 clk = ~clk;
  tmtc_top #(.ID_W(8)) dut (.clk(clk), .rst_n(rst_n), .remote_fire_input(remote_fire_input), .frameDone(frameDone),
    .frameStart(frameStart), .frameSpecial(frameSpecial), .frameKind(frameKind), .lineDriveOe_n(lineDriveOe_n),
    .validity_strobe(validity_strobe), .count_restart_pulse(count_restart_pulse), .sampleCount(sampleCount),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  tmtc_link_model u_link (.clk(clk), .rst_n(rst_n), .frameStart(frameStart), .latency(lat), .frameDone(frameDone),
    .busy(busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic fail(input string msg);
    n_fail++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) fail(msg);
  endtask
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded waits end the run when they expire
  task automatic guard(input logic ok);
    if (!ok) begin
      fail("wait timed out");
      results();
    end
  endtask
  task automatic idle();
    for (int i = 0; i < 30000; i++) begin
      @(posedge clk);
      if (fq.size() == 0 && !busy && validity_strobe) begin
        repeat (4) @(posedge clk);
        return;
      end
    end
    guard(1'b0);
  endtask
  // aw and w offered together, bready raised once both are taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    logic awOk;
    logic wOk;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      awOk = s_axi_awvalid && s_axi_awready;
      wOk = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid && s_axi_bready) begin
        @(posedge clk);
        s_axi_bready <= 1'b0;
        return;
      end
      @(posedge clk);
      if (awOk) s_axi_awvalid <= 1'b0;
      if (wOk) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end
    guard(1'b0);
  endtask
  // rready comes a cycle late so the held response is seen
  task automatic axiRd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic [1:0] r);
    logic arOk;
    rq.push_back('{v, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      arOk = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
        @(posedge clk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge clk);
      if (arOk) s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid) s_axi_rready <= 1'b1;
    end
    guard(1'b0);
  endtask
  // falling edge with random frame length; hi of 0 expects no frame
  task automatic trig(input int lo, input int hi, input logic sp, input logic [2:0] k);
    if (hi > 0) fq.push_back('{sp, k, lo, hi});
    rnd = lfsr(rnd);
    lat <= 8'(20 + rnd[5:0]);
    remote_fire_input <= 1'b0;
    repeat (3) @(posedge clk);
    remote_fire_input <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic doReset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(validity_strobe === 1'b1 && lineDriveOe_n === 1'b1 && frameStart === 1'b0, "reset state");
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // results watcher: oldest note against each answer
  always @(posedge clk) begin
    cyc++;
    if (prevFire && !remote_fire_input) fallCyc = cyc;
    prevFire = remote_fire_input;
    if (count_restart_pulse === 1'b1) wraps++;
    if (s_axi_bvalid && s_axi_bready) begin
      if (bq.size() == 0) fail("stray write response");
      else check(s_axi_bresp === bq.pop_front(), "write response");
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rx = rq.pop_front();
      check((s_axi_rdata & rx.m) === (rx.d & rx.m) && s_axi_rresp === rx.r, "read data");
    end
    if (kindDue) begin
      kindDue = 1'b0;
      check(frameSpecial === cur.sp && frameKind === cur.k, "frame kind");
    end
    if (frameStart === 1'b1) begin
      frames++;
      if (fq.size() > 0) begin
        cur = fq.pop_front();
        kindDue = 1'b1;
        check(cyc - fallCyc >= cur.lo && cyc - fallCyc <= cur.hi, "frame start time");
      end else if (strict) fail("unexpected frame");
    end
  end
  initial begin
    for (int k = 0; k < STARTUP_CNT; k++) fq.push_back('{1'b1, 3'(k), 0, 1000000});
    doReset();
    idle();
    axiRd(REG_CTRL, CTRL_RST, 32'hFFFFFFFF, RESP_OKAY);
    axiRd(REG_BAUD, 32'(BAUD_RST), 32'h0000FFFF, RESP_OKAY);
    axiRd(REG_FRAME, 32'(FRAME_RST), 32'h0000FFFF, RESP_OKAY);
    axiRd(REG_CNTMAX, 32'(CNTMAX_RST), 32'h0000FFFF, RESP_OKAY);
    axiRd(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axiWr(REG_STATUS, 32'h0, RESP_SLVERR);
    axiWr(REG_CTRL, 32'h2, RESP_OKAY);
    axiRd(REG_CTRL, 32'h0, 32'h7, RESP_OKAY);
    frames = 0;
    wraps = 0;
    axiWr(REG_CNTMAX, 32'h1, RESP_OKAY);
    for (int i = 0; i < 40000 && !(frames > 0 && wraps > 0); i++) @(posedge clk);
    check(frames > 0, "no free-run frame");
    check(wraps > 0, "no restart pulse");
    axiWr(REG_CTRL, 32'h1, RESP_OKAY);
    idle();
    strict = 1'b1;
    trig(0, 6, 1'b0, 3'h0);
    trig(0, 0, 1'b0, 3'h0);
    idle();
    rnd = lfsr(rnd);
    axiWr(REG_SPEC, {29'h0, rnd[2:0]}, RESP_OKAY);
    axiWr(REG_SPEC, {29'h0, ~rnd[2:0]}, RESP_OKAY);
    trig(0, 6, 1'b1, ~rnd[2:0]);
    idle();
    trig(0, 6, 1'b0, 3'h0);
    idle();
    axiWr(REG_CTRL, 32'h41, RESP_OKAY);
    trig(0, 0, 1'b0, 3'h0);
    repeat (100) @(posedge clk);
    check(lineDriveOe_n === 1'b1, "muted unit drives line");
    axiWr(REG_BAUD, 32'h2, RESP_OKAY);
    // lane 1 masked, only the low byte lands
    strb <= 4'h1;
    axiWr(REG_FRAME, 32'h0501, RESP_OKAY);
    strb <= 4'hF;
    axiRd(REG_FRAME, 32'h1, 32'hFFFF, RESP_OKAY);
    // multi-drop slot table: plain, parity and two stops, wide gap, long start step
    for (int c = 0; c < 4; c++) begin
      gap = (c == 2) ? 300 : 0;
      st = (c == 3) ? 3000 : 0;
      cl = START_BITS + DATA_BITS + ((c == 1) ? 3 : 1);
      slot = cl * 2 + ((gap > GAP_MIN_CYC) ? gap : GAP_MIN_CYC);
      d = (2 * st > PREP_CYC + 2 * slot) ? 2 * st : PREP_CYC + 2 * slot;
      axiWr(REG_GAP, 32'(gap), RESP_OKAY);
      axiWr(REG_START, 32'(st), RESP_OKAY);
      axiWr(REG_CTRL, 32'h3 | ((c == 1) ? 32'h30 : 32'h0) | (32'h2 << ID_LSB), RESP_OKAY);
      repeat (4) @(posedge clk);
      check(lineDriveOe_n === 1'b1, "driver on while idle");
      trig(d, d + 6, 1'b0, 3'h0);
      for (int i = 0; i < 8000 && !busy; i++) @(posedge clk);
      guard(busy);
      @(posedge clk);
      check(lineDriveOe_n === 1'b0, "driver off in frame");
      idle();
      check(lineDriveOe_n === 1'b1, "driver on after frame");
    end
    axiWr(REG_CTRL, 32'h1 | (32'h2 << ID_LSB), RESP_OKAY);
    axiRd(REG_CTRL, 32'h4, 32'h6, RESP_OKAY);
    trig(0, 6, 1'b0, 3'h0);
    idle();
    check(lineDriveOe_n === 1'b1, "driver kept on");
    axiWr(REG_CTRL, 32'h101 | (32'h2 << ID_LSB), RESP_OKAY);
    axiWr(REG_CTRL, 32'h101 | (32'h2 << ID_LSB), RESP_OKAY);
    axiRd(REG_CTRL, 32'h0, 32'h4, RESP_OKAY);
    trig(0, 6, 1'b0, 3'h0);
    for (int i = 0; i < 100 && !busy; i++) @(posedge clk);
    strict = 1'b0;
    for (int k = 0; k < STARTUP_CNT; k++) fq.push_back('{1'b1, 3'(k), 0, 1000000});
    doReset();
    idle();
    results();
  end
endmodule
